// file: inc/rmb_map.svh
// Register offsets, field positions, reset values and timing counts of the receive buffer control block.
// Assumes a 100 MHz pclk and a 32-bit APB slave port with word-aligned registers.
//
// Notes on behaviour
// - Receiving mode starts only after every programmed bit check passed.
// - Entering receiving mode sets the host clock enable bit to one.
// - Entering receiving mode interrupts only when transparent and pattern mode are zero.
// - Transparent mode with chip select idle drives raw stream on serial out pin.
// - Without transparent mode, Manchester or bi-phase data is buffered; readable anytime.
// - Receiving accepts only T and 2T spacings; T uses the bit check limits.
// - 2T limits are sum minus or plus half the difference, in clock periods.
// - Fractional 2T limits round up to the next integer.
// - After start bit, bytes are stored one at a time; start bit included.
// - More than sixteen unread bytes overwrite bytes already stored.
// - Byte counter increments per received byte, decrements per byte read.
// - Interrupt when the incrementing counter reaches the programmed threshold.
// - Outside transparent mode, a bit error interrupts and returns to start-up.
// - Bit error: spacing outside T or 2T windows, or missing mid-bit edge.
// - The byte holding a bit error is discarded.
// - Writing control registers 1, 4, 5, 6 or 7 while receiving resets buffer and counter.
// - After such a write, receive mode still selected restarts at start-up.
// - Rising edge decodes one, falling zero; transparent output follows carrier level.
// - T window is lower limit clocks up to upper limit minus one clocks.
// - The edge counter runs on the extended data clock period.
`ifndef RMB_MAP_SVH
`define RMB_MAP_SVH

`define RMB_ADDR_CTRL1     8'h00
`define RMB_ADDR_CTRL3     8'h04
`define RMB_ADDR_CTRL4     8'h08
`define RMB_ADDR_CTRL5     8'h0C
`define RMB_ADDR_CTRL6     8'h10
`define RMB_ADDR_CTRL7     8'h14
`define RMB_ADDR_STATUS    8'h18
`define RMB_ADDR_DATA      8'h1C
`define RMB_ADDR_WINDOW    8'h20

`define RMB_CTRL1_RESET    8'h00
`define RMB_CTRL3_RESET    8'h00
`define RMB_CTRL4_RESET    8'h00
`define RMB_CTRL5_RESET    8'h0D
`define RMB_CTRL6_RESET    8'h26
`define RMB_CTRL7_RESET    8'h00

`define RMB_OP_SEL_LSB     0
`define RMB_T_MODE_BIT     3
`define RMB_P_MODE_BIT     4
`define RMB_IRQ_LVL_LSB    5
`define RMB_LIM_LSB        0
`define RMB_BITCHK_LSB     6
`define RMB_STAT_CNT_LSB   4

`define RMB_OP_RX          3'h3
`define RMB_BUF_DEPTH      16
`define RMB_XDCLK_NS       1000
`define RMB_CLK_NS         10
`define RMB_XDCLK_CYCLES   (`RMB_XDCLK_NS / `RMB_CLK_NS)
`define RMB_STARTUP_TICKS  8'h10

`endif

// file: inc/rmb_pkg.sv
// Types shared by the receive buffer control block.
// Assumes rmb_map.svh provides the numeric constants.
package rmb_pkg;

   typedef enum logic [2:0] {
      RMB_IDLE,
      RMB_STARTUP,
      RMB_BITCHECK,
      RMB_HUNT,
      RMB_DATA
   } rmb_state_type;

   typedef struct packed {
      logic [1:0] irq_level;
      logic       pattern_mode;
      logic       transparent_mode;
      logic [2:0] op_sel;
   } rmb_ctrl1_type;

   typedef struct packed {
      logic [7:0] lower;
      logic [7:0] upper;
   } rmb_window_type;

endpackage : rmb_pkg

// file: core/rmb_core.sv
// Receive-mode bit check, Manchester edge-window decoding and 16-byte receive buffer with APB registers.
// Assumes demod_out and spi_cs_n are synchronous to pclk; one clock domain, APB slave answers without wait.
// Assumes the host drains the buffer in time; an overrun drops the oldest byte without notice.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`include "rmb_map.svh"
`timescale 1ns/1ps
`default_nettype none

module rmb_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        demod_out,
   input  wire logic        spi_cs_n,
   output var  logic        serial_out_transparent_pin,
   output var  logic        serial_out_transparent_oe,
   output var  logic        host_clk_en,
   output var  logic        irq
);

   localparam int DIV = `RMB_XDCLK_CYCLES;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == `RMB_ADDR_CTRL1) || (a == `RMB_ADDR_CTRL3) || (a == `RMB_ADDR_CTRL4) ||
                  (a == `RMB_ADDR_CTRL5) || (a == `RMB_ADDR_CTRL6) || (a == `RMB_ADDR_CTRL7) ||
                  (a == `RMB_ADDR_STATUS) || (a == `RMB_ADDR_DATA) || (a == `RMB_ADDR_WINDOW);
   endfunction : is_mapped

   function automatic logic is_cfg(input logic [7:0] a);
      is_cfg = (a == `RMB_ADDR_CTRL1) || (a == `RMB_ADDR_CTRL4) || (a == `RMB_ADDR_CTRL5) ||
               (a == `RMB_ADDR_CTRL6) || (a == `RMB_ADDR_CTRL7);
   endfunction : is_cfg

   // Half-open window shared by the bit check and the receive decoder
   function automatic logic in_window(input logic [7:0] cnt, input logic [7:0] lo, input logic [7:0] hi);
      in_window = (cnt >= lo) && (cnt < hi);
   endfunction : in_window

   rmb_pkg::rmb_ctrl1_type  ctrl1_reg;
   logic                    ctrl3_reg;
   logic [7:0]              ctrl4_reg;
   logic [7:0]              ctrl5_reg;
   logic [7:0]              ctrl6_reg;
   logic [7:0]              ctrl7_reg;
   rmb_pkg::rmb_state_type  state_reg;
   logic [7:0]              div_reg;
   logic                    tick;
   logic [7:0]              edge_counter_value;
   logic [7:0]              wait_reg;
   logic                    demod_reg;
   logic                    edge_seen;
   logic                    armed_reg;
   logic [4:0]              checks_reg;
   logic [4:0]              checks_need;
   logic                    mid_reg;
   logic [7:0]              shift_reg;
   logic [2:0]              bits_reg;
   logic [7:0]              mem [0:`RMB_BUF_DEPTH-1];
   logic [3:0]              wr_ptr_reg;
   logic [3:0]              rd_ptr_reg;
   logic [4:0]              fill_reg;
   logic [4:0]              threshold;
   logic [5:0]              lim_min;
   logic [5:0]              lim_max;
   logic [7:0]              span;
   logic [7:0]              sum;
   rmb_pkg::rmb_window_type double_win;
   logic [7:0]              double_window_lower;
   logic [7:0]              double_window_upper;
   logic                    acc;
   logic                    wr_acc;
   logic                    rd_pop;
   logic                    cfg_wr;
   logic                    receiving;
   logic                    rx_next_sel;
   logic                    t_ok;
   logic                    t2_ok;
   logic                    bad_spacing;
   logic                    timeout;
   logic                    bit_valid;
   logic                    bit_val;
   logic                    bit_err;
   logic                    byte_done;
   logic                    enter_rx;
   logic                    pop_ok_reg;
   logic                    pass_through;

   assign lim_min = ctrl5_reg[`RMB_LIM_LSB +: 6];
   assign lim_max = ctrl6_reg[`RMB_LIM_LSB +: 6];
   // ASK and FSK decode alike, so control 4 is storage only

   // Difference clamped at zero so a lower limit above the upper one cannot wrap
   assign span = (lim_max > lim_min) ? {2'h0, lim_max - lim_min} : 8'h00;
   assign sum  = {2'h0, lim_min} + {2'h0, lim_max};
   assign double_window_lower = sum - {1'h0, span[7:1]};
   assign double_window_upper = sum + {1'h0, span[7:1]} + {7'h00, span[0]};
   assign double_win = '{lower: double_window_lower, upper: double_window_upper};

   // Extended data clock tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 8'h00;
      end else if (div_reg == 8'(DIV - 1)) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end
   assign tick = (div_reg == 8'(DIV - 1));

   // APB handshake: zero wait states
   assign acc     = psel && penable;
   assign pready  = 1'b1;
   assign pslverr = acc && !is_mapped(paddr);
   assign wr_acc  = acc && pwrite && is_mapped(paddr);
   assign rd_pop  = acc && !pwrite && (paddr == `RMB_ADDR_DATA) && (fill_reg != 5'h00) && pop_ok_reg;
   assign receiving = (state_reg == rmb_pkg::RMB_HUNT) || (state_reg == rmb_pkg::RMB_DATA);
   assign cfg_wr    = wr_acc && is_cfg(paddr) && receiving;
   assign rx_next_sel = (paddr == `RMB_ADDR_CTRL1) ?
                        (pwdata[`RMB_OP_SEL_LSB +: 3] == `RMB_OP_RX) : (ctrl1_reg.op_sel == `RMB_OP_RX);

   // Writes to read-only or unmapped offsets are dropped here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_reg <= rmb_pkg::rmb_ctrl1_type'(7'(`RMB_CTRL1_RESET));
         ctrl4_reg <= `RMB_CTRL4_RESET;
         ctrl5_reg <= `RMB_CTRL5_RESET;
         ctrl6_reg <= `RMB_CTRL6_RESET;
         ctrl7_reg <= `RMB_CTRL7_RESET;
      end else if (wr_acc) begin
         case (paddr)
            `RMB_ADDR_CTRL1: ctrl1_reg <= rmb_pkg::rmb_ctrl1_type'(pwdata[6:0]);
            `RMB_ADDR_CTRL4: ctrl4_reg <= pwdata[7:0];
            `RMB_ADDR_CTRL5: ctrl5_reg <= pwdata[7:0];
            `RMB_ADDR_CTRL6: ctrl6_reg <= pwdata[7:0];
            `RMB_ADDR_CTRL7: ctrl7_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Host clock enable: hardware set on receive entry wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl3_reg <= 1'(`RMB_CTRL3_RESET);
      end else if (enter_rx) begin
         ctrl3_reg <= 1'b1;
      end else if (wr_acc && (paddr == `RMB_ADDR_CTRL3)) begin
         ctrl3_reg <= pwdata[0];
      end
   end
   assign host_clk_en = ctrl3_reg;

   // Read data captured in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `RMB_ADDR_CTRL1:  prdata <= {25'h0, ctrl1_reg};
            `RMB_ADDR_CTRL3:  prdata <= {31'h0, ctrl3_reg};
            `RMB_ADDR_CTRL4:  prdata <= {24'h0, ctrl4_reg};
            `RMB_ADDR_CTRL5:  prdata <= {24'h0, ctrl5_reg};
            `RMB_ADDR_CTRL6:  prdata <= {24'h0, ctrl6_reg};
            `RMB_ADDR_CTRL7:  prdata <= {24'h0, ctrl7_reg};
            `RMB_ADDR_STATUS: prdata <= {23'h0, fill_reg, 1'b0, state_reg};
            `RMB_ADDR_DATA:   prdata <= (fill_reg != 5'h00) ? {24'h0, mem[rd_ptr_reg]} : 32'h0;
            `RMB_ADDR_WINDOW: prdata <= {16'h0, double_win};
            default:          prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Pop only a byte that the setup cycle returned; a byte landing between
   // setup and access would otherwise be counted out without being read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pop_ok_reg <= 1'b0;
      end else if (psel && !penable) begin
         pop_ok_reg <= !pwrite && (paddr == `RMB_ADDR_DATA) && (fill_reg != 5'h00);
      end
   end

   // Edge detection and edge-to-edge counter
   assign edge_seen = (demod_out != demod_reg);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         demod_reg <= 1'b0;
      end else begin
         demod_reg <= demod_out;
      end
   end

   // Restarts on receive entry too, so silence before entry is not taken as a timeout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_counter_value <= 8'h00;
      end else if (edge_seen || state_reg == rmb_pkg::RMB_STARTUP || state_reg == rmb_pkg::RMB_IDLE || enter_rx) begin
         edge_counter_value <= 8'h00;
      end else if (tick && edge_counter_value != 8'hFF) begin
         edge_counter_value <= edge_counter_value + 8'h01;
      end
   end

   // Window checks made at an edge against the count since the previous one
   // Upper bounds are exclusive, matching the value-minus-one upper times
   assign t_ok  = in_window(edge_counter_value, {2'h0, lim_min}, {2'h0, lim_max});
   assign t2_ok = in_window(edge_counter_value, double_window_lower, double_window_upper);
   assign bad_spacing = edge_seen && !t_ok && !t2_ok;
   assign timeout     = (edge_counter_value >= double_window_upper);

   // Mid-bit edge direction gives the bit: rising is one, falling is zero
   assign bit_val = demod_out;
   assign bit_valid = edge_seen && ((state_reg == rmb_pkg::RMB_HUNT && t2_ok) ||
                      (state_reg == rmb_pkg::RMB_DATA && ((mid_reg && t2_ok) || (!mid_reg && t_ok))));
   // A 2T gap from a bit boundary means no edge came in the bit centre
   assign bit_err = receiving && (bad_spacing || (!edge_seen && timeout) ||
                    (state_reg == rmb_pkg::RMB_DATA && edge_seen && !mid_reg && t2_ok && !t_ok));
   assign byte_done = bit_valid && (bits_reg == 3'h7);

   assign checks_need = {ctrl5_reg[`RMB_BITCHK_LSB +: 2], 1'b0} +
                        {1'b0, ctrl5_reg[`RMB_BITCHK_LSB +: 2], 2'h0};
   assign enter_rx = (state_reg == rmb_pkg::RMB_BITCHECK) && !cfg_wr &&
                     (checks_reg >= checks_need) && (ctrl1_reg.op_sel == `RMB_OP_RX);

   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg  <= rmb_pkg::RMB_IDLE;
         wait_reg   <= 8'h00;
         armed_reg  <= 1'b0;
         checks_reg <= 5'h00;
         mid_reg    <= 1'b0;
      end else if (cfg_wr) begin
         state_reg  <= rx_next_sel ? rmb_pkg::RMB_STARTUP : rmb_pkg::RMB_IDLE;
         wait_reg   <= 8'h00;
      end else if (ctrl1_reg.op_sel != `RMB_OP_RX) begin
         state_reg  <= rmb_pkg::RMB_IDLE;
      end else begin
         case (state_reg)
            rmb_pkg::RMB_IDLE: begin
               state_reg <= rmb_pkg::RMB_STARTUP;
               wait_reg  <= 8'h00;
            end
            rmb_pkg::RMB_STARTUP: begin
               if (wait_reg >= `RMB_STARTUP_TICKS) begin
                  state_reg  <= rmb_pkg::RMB_BITCHECK;
                  armed_reg  <= 1'b0;
                  checks_reg <= 5'h00;
               end else if (tick) begin
                  wait_reg <= wait_reg + 8'h01;
               end
            end
            rmb_pkg::RMB_BITCHECK: begin
               if (enter_rx) begin
                  state_reg <= rmb_pkg::RMB_HUNT;
               end else if (edge_seen) begin
                  armed_reg <= 1'b1;
                  // First edge only starts the measurement
                  if (armed_reg && t_ok) begin
                     checks_reg <= checks_reg + 5'h01;
                  end else if (armed_reg) begin
                     state_reg <= rmb_pkg::RMB_STARTUP;
                     wait_reg  <= 8'h00;
                  end
               end else if (armed_reg && edge_counter_value >= {2'h0, lim_max}) begin
                  state_reg <= rmb_pkg::RMB_STARTUP;
                  wait_reg  <= 8'h00;
               end
            end
            rmb_pkg::RMB_HUNT, rmb_pkg::RMB_DATA: begin
               if (ctrl1_reg.transparent_mode) begin
                  state_reg <= rmb_pkg::RMB_HUNT;
               end else if (bit_err) begin
                  state_reg <= rmb_pkg::RMB_STARTUP;
                  wait_reg  <= 8'h00;
               end else if (edge_seen) begin
                  if (state_reg == rmb_pkg::RMB_HUNT) begin
                     // Preburst is all T gaps; the first 2T gap ends in the start bit centre
                     if (t2_ok) begin
                        state_reg <= rmb_pkg::RMB_DATA;
                        mid_reg   <= 1'b1;
                     end
                  end else begin
                     mid_reg <= t2_ok ? 1'b1 : !mid_reg;
                  end
               end
            end
            default: state_reg <= rmb_pkg::RMB_IDLE;
         endcase
      end
   end

   // Bit packing, start bit first, oldest bit ends in the MSB
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_reg <= 8'h00;
         bits_reg  <= 3'h0;
      end else if (cfg_wr || bit_err || !receiving || ctrl1_reg.transparent_mode) begin
         shift_reg <= 8'h00;
         bits_reg  <= 3'h0;
      end else if (bit_valid) begin
         shift_reg <= {shift_reg[6:0], bit_val};
         bits_reg  <= bits_reg + 3'h1;
      end
   end

   // Receive buffer: a full buffer keeps taking bytes and drops the oldest
   always_ff @(posedge pclk) begin
      if (byte_done && !bit_err && !cfg_wr) begin
         mem[wr_ptr_reg] <= {shift_reg[6:0], bit_val};
      end
   end

   // Pointers and fill count; a configuration write in receive empties the buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= 4'h0;
         rd_ptr_reg <= 4'h0;
         fill_reg   <= 5'h00;
      end else if (cfg_wr) begin
         wr_ptr_reg <= 4'h0;
         rd_ptr_reg <= 4'h0;
         fill_reg   <= 5'h00;
      end else begin
         if (byte_done && !bit_err) begin
            wr_ptr_reg <= wr_ptr_reg + 4'h1;
         end
         if (byte_done && !bit_err && fill_reg == 5'(`RMB_BUF_DEPTH) && !rd_pop) begin
            rd_ptr_reg <= rd_ptr_reg + 4'h1;
         end else if (rd_pop) begin
            rd_ptr_reg <= rd_ptr_reg + 4'h1;
         end
         if (byte_done && !bit_err && !rd_pop && fill_reg != 5'(`RMB_BUF_DEPTH)) begin
            fill_reg <= fill_reg + 5'h01;
         end else if (rd_pop && !(byte_done && !bit_err)) begin
            fill_reg <= fill_reg - 5'h01;
         end
      end
   end

   // Threshold 4, 8, 12 or 16 bytes from the two level bits
   assign threshold = {ctrl1_reg.irq_level, 2'h0} + 5'h04;

   // One pulse per event; events on adjacent cycles merge into a two-cycle pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= (enter_rx && !ctrl1_reg.transparent_mode && !ctrl1_reg.pattern_mode) ||
                (byte_done && !bit_err && !cfg_wr && !rd_pop && fill_reg + 5'h01 == threshold) ||
                (bit_err && !cfg_wr && !ctrl1_reg.transparent_mode);
      end
   end

   // Transparent output only while the serial interface is idle
   // Chip select low hands the pin back to the serial interface
   assign pass_through = receiving && ctrl1_reg.transparent_mode && spi_cs_n;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_out_transparent_pin <= 1'b0;
         serial_out_transparent_oe  <= 1'b0;
      end else begin
         serial_out_transparent_oe  <= pass_through;
         serial_out_transparent_pin <= pass_through && demod_out;
      end
   end

endmodule : rmb_core

`default_nettype wire

// file: verification/rmb_core_asserts.sv
// Port checker for rmb_core, bound into it.
// Assumes one pclk domain and asynchronous active-low presetn.
`include "rmb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rmb_core_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        demod_out,
   input wire logic        spi_cs_n,
   input wire logic        serial_out_transparent_pin,
   input wire logic        serial_out_transparent_oe,
   input wire logic        host_clk_en,
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   transp_data_a: assert property (serial_out_transparent_oe |-> serial_out_transparent_pin == $past(demod_out))
      else $error("transparent pin wrong");
   transp_cs_a: assert property (!spi_cs_n |=> !serial_out_transparent_oe)
      else $error("transparent pin driven in transfer");
   transp_idle_a: assert property (!serial_out_transparent_oe |-> !serial_out_transparent_pin)
      else $error("undriven pin high");
   irq_pulse_a: assert property (irq |=> !irq)
      else $error("interrupt too long");
   clk_en_hold_a: assert property ($fell(host_clk_en) |->
      $past(psel && penable && pwrite && paddr == `RMB_ADDR_CTRL3)) else $error("clock enable lost");
   rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
      else $error("read data moved");
   ready_a: assert property (psel && penable |-> pready)
      else $error("no answer");
   slverr_a: assert property (psel && penable && paddr > `RMB_ADDR_WINDOW |-> pslverr)
      else $error("unmapped access not flagged");
   cover property (irq);
   cover property (serial_out_transparent_oe);
   cover property (pslverr);
   cover property ($fell(host_clk_en));
endmodule : rmb_core_asserts
bind rmb_core rmb_core_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .demod_out, .spi_cs_n, .serial_out_transparent_pin, .serial_out_transparent_oe, .host_clk_en, .irq);
`default_nettype wire

// file: verification/rmb_tx_model.sv
// Manchester transmitter as seen through the demodulator.
// Assumes HALF pclk cycles per half bit; the line keeps its level between frames.
`timescale 1ns/1ps
`default_nettype none
module rmb_tx_model #(
   parameter int HALF = 650
) (
   input  wire logic pclk,
   output var  logic demod_out
);
   initial demod_out = 1'h0;
   // Mid-bit rise sends one, fall sends zero
   task automatic send_bit(input logic b);
      repeat (HALF) @(posedge pclk);
      demod_out <= ~b;
      repeat (HALF) @(posedge pclk);
      demod_out <= b;
   endtask : send_bit
   // Zeros preburst, so the leading data bit must be a one
   task automatic send_frame(input int pre, input logic [39:0] data, input int nbits);
      repeat (pre) send_bit(1'h0);
      for (int i = 39; i > 39 - nbits; i--) send_bit(data[i]);
   endtask : send_frame
   // Gap well below the T window
   task automatic break_edge;
      repeat (HALF / 2) @(posedge pclk);
      demod_out <= ~demod_out;
   endtask : break_edge
endmodule : rmb_tx_model
`default_nettype wire

// file: verification/test_rx_manchester_buffer_control.sv
// Self-checking bench for rmb_core: APB traffic and Manchester frames.
// Assumes rmb_tx_model drives demod_out and the checker is bound in.
`include "rmb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_rx_manchester_buffer_control;
   logic        pclk, presetn, psel, penable, pwrite, spi_cs_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, r, exp_q[$], msk_q[$];
   wire  [31:0] prdata;
   wire         pready, pslverr, demod_out, so_pin, so_oe, host_clk_en, irq;
   int          miscompares = 0, check_count = 0, irq_count = 0;
   integer      seed = 32'h93FD7094;
   localparam logic [31:0] BYTES = 32'hA53C96E1;
   rmb_core DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .demod_out,
      .spi_cs_n, .serial_out_transparent_pin(so_pin), .serial_out_transparent_oe(so_oe), .host_clk_en, .irq);
   rmb_tx_model #(.HALF(650)) u_tx (.pclk, .demod_out);
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_sim;
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // Request holds until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk = 32'hFFFFFFFF);
      exp_q.push_back(exp);
      msk_q.push_back(msk);
      apb(1'h0, a, 32'h0);
   endtask : rd
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'h1 && exp_q.size() > 0)
         check("prdata", prdata & msk_q.pop_front(), exp_q.pop_front());
      if (irq === 1'h1)
         irq_count++;
   end
   initial begin
      #1000000;
      miscompares++;
      end_sim;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      spi_cs_n = 1'h1;
      presetn = 1'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rd(`RMB_ADDR_CTRL5, 32'h0D);
      rd(`RMB_ADDR_CTRL6, 32'h26);
      rd(8'h40, 32'h0);
      r = $random(seed);
      apb(1'h1, `RMB_ADDR_CTRL7, r);
      rd(`RMB_ADDR_CTRL7, r & 32'hFF);
      apb(1'h1, `RMB_ADDR_CTRL5, 32'h84);
      apb(1'h1, `RMB_ADDR_CTRL6, 32'h09);
      rd(`RMB_ADDR_WINDOW, 32'h0B10);
      apb(1'h1, `RMB_ADDR_CTRL1, 32'h03);
      // Four whole bytes then a broken fifth: threshold reached, partial byte lost
      u_tx.send_frame(10, 40'hA53C96E1F0, 36);
      u_tx.break_edge();
      for (int i = 0; i < 5000 && irq_count < 3; i++) @(posedge pclk);
      check("irq events", irq_count, 3);
      rd(`RMB_ADDR_CTRL3, 32'h1, 32'h1);
      check("host clk en", host_clk_en, 1);
      apb(1'h1, `RMB_ADDR_CTRL3, 32'h0);
      rd(`RMB_ADDR_CTRL3, 32'h0, 32'h1);
      rd(`RMB_ADDR_STATUS, 32'h40, 32'h1F0);
      for (int i = 0; i < 4; i++) rd(`RMB_ADDR_DATA, {24'h0, BYTES[31-8*i -: 8]});
      rd(`RMB_ADDR_STATUS, 32'h0, 32'h1F0);
      rd(`RMB_ADDR_DATA, 32'h0);
      apb(1'h1, `RMB_ADDR_CTRL1, 32'h0B);
      u_tx.send_frame(10, 40'h0, 0);
      check("irq events", irq_count, 3);
      check("host clk en", host_clk_en, 1);
      check("transparent oe", so_oe, 1);
      spi_cs_n <= 1'h0;
      repeat (2) @(posedge pclk);
      check("transparent oe", so_oe, 0);
      end_sim;
   end
endmodule : test_rx_manchester_buffer_control
`default_nettype wire
